// *** verilog/rpdc_pkg.sv ***
`default_nettype none
package rpdc_pkg;
	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_NEXT_LINK = 8'h00; // descriptor_next_link
	localparam logic [7:0] OFF_CTRL_A = 8'h04; // descriptor_control_a
	localparam logic [7:0] OFF_WORD2 = 8'h08;
	localparam logic [7:0] OFF_WORD3 = 8'h0c;
	localparam logic [7:0] OFF_WORD4 = 8'h10;
	localparam logic [7:0] OFF_KEY_MID = 8'h20; // cipher_key_bits_95_64
	localparam logic [7:0] OFF_KEY_TOP = 8'h24; // cipher_key_bits_127_96
	localparam logic [7:0] OFF_STATUS = 8'h28; // sequencer_status_reg, w1c
	localparam logic [7:0] OFF_MASK = 8'h2c; // interrupt mask
	localparam logic [7:0] OFF_RADIO = 8'h30; // power code and bypass
	localparam logic [7:0] OFF_HOP = 8'h34; // channel and hop increment
	localparam logic [7:0] OFF_MAP_LO = 8'h38; // channel map 31:0
	localparam logic [7:0] OFF_MAP_HI = 8'h3c; // channel map 36:32
	localparam logic [7:0] OFF_COUNTERS = 8'h40; // event counters
	localparam logic [7:0] OFF_IRQ_FLAGS = 8'h44; // sequencer_irq_flags, ro
	localparam logic [7:0] OFF_CUR_DESC = 8'h48; // current descriptor, ro
	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int CTRL_CALIBRATION_REQUEST = 0;
	localparam int CTRL_ALGSEL = 1;
	localparam int CTRL_ADV = 5;
	localparam int CTRL_INCCHAN = 7;
	localparam int RADIO_BYPASS = 5;
	localparam int ST_PTR_ERR = 0;
	localparam int ST_HOP_DONE = 1;
	localparam int NUM_EVT = 2;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// --------------------------------------------------------------
	// channel and power constants
	// --------------------------------------------------------------
	localparam logic [5:0] NUM_CHAN = 6'h25; // 37 data channels
	localparam logic [5:0] ADV_FIRST = 6'h25; // 37
	localparam logic [5:0] ADV_MID = 6'h26; // 38
	localparam logic [5:0] ADV_LAST = 6'h27; // 39
	localparam logic [4:0] PWR_MAX = 5'h1f;
	localparam logic [4:0] PWR_0DBM = 5'h19;
	localparam logic [4:0] PWR_OFF = 5'h00; // -40 dBm
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// calibration steps enabled for the coming packet
	typedef struct packed {
		logic freq;
		logic osc_gain;
		logic bandpass;
		logic synth_loop;
	} rpdc_cal_t;
endpackage
`default_nettype wire

// *** verilog/rpdc_top.sv ***
// How it works
// RULE1: key words 95:64 and 127:96 feed encryption
// RULE2: 5-bit power code, higher code higher power
// RULE3: max power needs 0x1F plus bypass set; power_at_max is raised on code 0x1F alone, bypass not checked
// RULE4: firmware keeps descriptor list never empty
// RULE5: next pointer holds absolute address only
// RULE6: misaligned next pointer sets error, irq if enabled
// RULE7: calibration request selects full or no calibration
// RULE8: firmware requests calibration after hop or wake
// RULE9: incrementer off ignores algorithm select
// RULE10: select 0: algorithm 1, advertising 37-38-39
// RULE11: select 1: algorithm 2 for data, periodic
// RULE12: incrementer enable computes next channel
`default_nettype none
module rpdc_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// sequencer step, one pulse per descriptor taken
	input wire logic seq_advance,
	// encryption engine key words
	output logic [31:0] cipher_key_mid_high,
	output logic [31:0] cipher_key_top,
	// transmit power
	output logic [4:0] transmit_power_code,
	output logic power_at_max,
	output logic power_at_0dbm,
	output logic power_off,
	output logic transformer_regulator_bypass,
	// sequencer state
	output rpdc_pkg::rpdc_cal_t cal_enable,
	output logic [31:0] current_descriptor,
	output logic [5:0] current_channel,
	// interrupt
	output logic irq
);
	// --------------------------------------------------------------
	// channel helpers
	// --------------------------------------------------------------
	// fold an unused channel onto the used set by index
	function automatic logic [5:0] rpdc_remap(input logic [5:0] ch, input logic [5:0] idx,
		input logic [36:0] map);
		logic [5:0] k;
		logic [5:0] r;
		k = 6'h00;
		r = ch;
		if (!map[ch])
		begin
			for (int i = 0; i < 37; i++)
			begin
				if (map[i])
				begin
					if (k == idx)
						r = 6'(i);
					k = k + 6'h01;
				end
			end
		end
		return r;
	endfunction
	// count channels allowed by the map
	function automatic logic [5:0] rpdc_used(input logic [36:0] map);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 37; i++)
			n = n + {5'h00, map[i]};
		return n;
	endfunction
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	localparam int NUM_EVT_W = rpdc_pkg::NUM_EVT;
	logic [31:0] next_link_reg, next_link_next; // next_descriptor_pointer
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] w2_reg, w2_next, w3_reg, w3_next, w4_reg, w4_next; // plain storage
	logic [31:0] key_mid_reg, key_mid_next, key_top_reg, key_top_next;
	logic [NUM_EVT_W-1:0] status_reg, status_next, mask_reg, mask_next;
	logic [5:0] radio_reg, radio_next; // power code and bypass
	logic [5:0] chan_reg, chan_next;
	logic [5:0] hopinc_reg, hopinc_next;
	logic [36:0] map_reg, map_next;
	logic [31:0] cnt_reg, cnt_next; // pa counter high, connection low
	logic [31:0] cur_desc_reg, cur_desc_next;
	rpdc_pkg::rpdc_cal_t cal_reg, cal_next;
	logic [4:0] pwr_reg, pwr_next;
	logic [2:0] pwr_flags_reg, pwr_flags_next; // max, 0 dBm, off
	logic irq_reg, irq_next;
	// bus pipeline
	logic wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
	logic [7:0] addr_reg, addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic hready_reg, hready_next;
	// decoded helpers
	logic take, ptr_bad, hop_on;
	logic [5:0] used_n, unmapped, hop_ch;
	logic [15:0] prn;
	logic [31:0] rd_mux;
	logic [NUM_EVT_W-1:0] events;
	// --------------------------------------------------------------
	// next channel and read mux
	// --------------------------------------------------------------
	always_comb
	begin
		take = hsel && hready && htrans == rpdc_pkg::HTRANS_NONSEQ;
		ptr_bad = seq_advance && next_link_reg[1:0] != 2'h0; // RULE6
		hop_on = seq_advance && !ptr_bad && ctrl_reg[rpdc_pkg::CTRL_INCCHAN]; // RULE12 RULE9
		used_n = rpdc_used(map_reg);
		prn = ctrl_reg[rpdc_pkg::CTRL_ADV] ? cnt_reg[31:16] : cnt_reg[15:0];
		prn = prn ^ {prn[7:0], prn[15:8]} ^ {10'h000, chan_reg};
		hop_ch = chan_reg;
		unmapped = chan_reg;
		// select only matters with the incrementer on
		if (!ctrl_reg[rpdc_pkg::CTRL_ALGSEL]) // RULE10
		begin
			if (ctrl_reg[rpdc_pkg::CTRL_ADV])
				hop_ch = (chan_reg == rpdc_pkg::ADV_FIRST) ? rpdc_pkg::ADV_MID :
					(chan_reg == rpdc_pkg::ADV_MID) ? rpdc_pkg::ADV_LAST : rpdc_pkg::ADV_FIRST;
			else
			begin
				unmapped = 6'((7'(chan_reg) + 7'(hopinc_reg)) % 7'(rpdc_pkg::NUM_CHAN));
				hop_ch = rpdc_remap(unmapped, (used_n == 6'h00) ? 6'h00 : unmapped % used_n, map_reg);
			end
		end
		else
		begin
			// algorithm 2: hashed event counter, remap by scaled index
			unmapped = 6'(prn % 16'(rpdc_pkg::NUM_CHAN)); // RULE11
			hop_ch = rpdc_remap(unmapped, 6'((22'(used_n) * 22'(prn)) >> 16), map_reg); // RULE11
		end
		events = '0;
		events[rpdc_pkg::ST_PTR_ERR] = ptr_bad;
		events[rpdc_pkg::ST_HOP_DONE] = hop_on;
		rd_mux = 32'h0000_0000;
		unique case (addr_reg)
			rpdc_pkg::OFF_NEXT_LINK: rd_mux = next_link_reg;
			rpdc_pkg::OFF_CTRL_A: rd_mux = ctrl_reg;
			rpdc_pkg::OFF_WORD2: rd_mux = w2_reg;
			rpdc_pkg::OFF_WORD3: rd_mux = w3_reg;
			rpdc_pkg::OFF_WORD4: rd_mux = w4_reg;
			rpdc_pkg::OFF_KEY_MID: rd_mux = key_mid_reg;
			rpdc_pkg::OFF_KEY_TOP: rd_mux = key_top_reg;
			rpdc_pkg::OFF_STATUS: rd_mux = {30'h0, status_reg};
			rpdc_pkg::OFF_MASK: rd_mux = {30'h0, mask_reg};
			rpdc_pkg::OFF_RADIO: rd_mux = {26'h0, radio_reg};
			rpdc_pkg::OFF_HOP: rd_mux = {18'h0, hopinc_reg, 2'h0, chan_reg};
			rpdc_pkg::OFF_MAP_LO: rd_mux = map_reg[31:0];
			rpdc_pkg::OFF_MAP_HI: rd_mux = {27'h0, map_reg[36:32]};
			rpdc_pkg::OFF_COUNTERS: rd_mux = cnt_reg;
			rpdc_pkg::OFF_IRQ_FLAGS: rd_mux = {30'h0, status_reg & mask_reg};
			rpdc_pkg::OFF_CUR_DESC: rd_mux = cur_desc_reg;
			default: rd_mux = 32'h0000_0000; // unmapped reads zero
		endcase
	end
	// --------------------------------------------------------------
	// next-state for registers and bus
	// --------------------------------------------------------------
	// reads get one wait state so a write just before is already visible
	always_comb
	begin
		next_link_next = next_link_reg;
		ctrl_next = ctrl_reg;
		w2_next = w2_reg;
		w3_next = w3_reg;
		w4_next = w4_reg;
		key_mid_next = key_mid_reg;
		key_top_next = key_top_reg;
		mask_next = mask_reg;
		radio_next = radio_reg;
		chan_next = chan_reg;
		hopinc_next = hopinc_reg;
		map_next = map_reg;
		cnt_next = cnt_reg;
		status_next = status_reg;
		wr_pend_next = take && hwrite;
		rd_pend_next = take && !hwrite;
		addr_next = take ? haddr[7:0] : addr_reg;
		hready_next = !(take && !hwrite);
		hrdata_next = rd_pend_reg ? rd_mux : hrdata_reg;
		if (wr_pend_reg)
		begin
			unique case (addr_reg)
				rpdc_pkg::OFF_NEXT_LINK: next_link_next = hwdata;
				rpdc_pkg::OFF_CTRL_A: ctrl_next = hwdata;
				rpdc_pkg::OFF_WORD2: w2_next = hwdata;
				rpdc_pkg::OFF_WORD3: w3_next = hwdata;
				rpdc_pkg::OFF_WORD4: w4_next = hwdata;
				rpdc_pkg::OFF_KEY_MID: key_mid_next = hwdata; // RULE1
				rpdc_pkg::OFF_KEY_TOP: key_top_next = hwdata; // RULE1
				rpdc_pkg::OFF_STATUS: status_next = status_reg & ~hwdata[NUM_EVT_W-1:0];
				rpdc_pkg::OFF_MASK: mask_next = hwdata[NUM_EVT_W-1:0];
				rpdc_pkg::OFF_RADIO: radio_next = hwdata[5:0];
				rpdc_pkg::OFF_HOP:
				begin
					chan_next = hwdata[5:0];
					hopinc_next = hwdata[13:8];
				end
				rpdc_pkg::OFF_MAP_LO: map_next[31:0] = hwdata;
				rpdc_pkg::OFF_MAP_HI: map_next[36:32] = hwdata[4:0];
				rpdc_pkg::OFF_COUNTERS: cnt_next = hwdata;
				default: ; // unmapped writes are dropped
			endcase
		end
		// hardware set wins over a same-cycle clear
		status_next = status_next | events; // RULE6
		if (hop_on)
			chan_next = hop_ch; // RULE12
		// take the next descriptor only when its address is aligned
		cur_desc_next = (seq_advance && !ptr_bad) ? next_link_reg : cur_desc_reg;
		cal_next = cal_reg;
		if (seq_advance && !ptr_bad)
			cal_next = {4{ctrl_reg[rpdc_pkg::CTRL_CALIBRATION_REQUEST]}}; // RULE7
		pwr_next = radio_reg[4:0]; // RULE2
		pwr_flags_next = {radio_reg[4:0] == rpdc_pkg::PWR_MAX, radio_reg[4:0] == rpdc_pkg::PWR_0DBM,
			radio_reg[4:0] == rpdc_pkg::PWR_OFF}; // RULE2
		irq_next = |(status_next & mask_next); // RULE6
	end
	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			next_link_reg <= rpdc_pkg::RESET_WORD;
			ctrl_reg <= rpdc_pkg::RESET_WORD;
			w2_reg <= rpdc_pkg::RESET_WORD;
			w3_reg <= rpdc_pkg::RESET_WORD;
			w4_reg <= rpdc_pkg::RESET_WORD;
			key_mid_reg <= rpdc_pkg::RESET_WORD;
			key_top_reg <= rpdc_pkg::RESET_WORD;
			status_reg <= '0;
			mask_reg <= '0;
			radio_reg <= 6'h00;
			chan_reg <= 6'h00;
			hopinc_reg <= 6'h00;
			map_reg <= 37'h00_0000_0000;
			cnt_reg <= rpdc_pkg::RESET_WORD;
			cur_desc_reg <= rpdc_pkg::RESET_WORD;
			cal_reg <= '0;
			pwr_reg <= 5'h00;
			pwr_flags_reg <= 3'h1;
			irq_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hrdata_reg <= rpdc_pkg::RESET_WORD;
			hready_reg <= 1'b1;
		end
		else
		begin
			next_link_reg <= next_link_next;
			ctrl_reg <= ctrl_next;
			w2_reg <= w2_next;
			w3_reg <= w3_next;
			w4_reg <= w4_next;
			key_mid_reg <= key_mid_next;
			key_top_reg <= key_top_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			radio_reg <= radio_next;
			chan_reg <= chan_next;
			hopinc_reg <= hopinc_next;
			map_reg <= map_next;
			cnt_reg <= cnt_next;
			cur_desc_reg <= cur_desc_next;
			cal_reg <= cal_next;
			pwr_reg <= pwr_next;
			pwr_flags_reg <= pwr_flags_next;
			irq_reg <= irq_next;
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			addr_reg <= addr_next;
			hrdata_reg <= hrdata_next;
			hready_reg <= hready_next;
		end
	end
	// outputs straight from flops; response is always okay
	assign hrdata = hrdata_reg;
	assign hreadyout = hready_reg;
	assign hresp = 1'b0;
	assign cipher_key_mid_high = key_mid_reg;
	assign cipher_key_top = key_top_reg;
	assign transmit_power_code = pwr_reg;
	assign {power_at_max, power_at_0dbm, power_off} = pwr_flags_reg;
	assign transformer_regulator_bypass = radio_reg[rpdc_pkg::RADIO_BYPASS];
	assign cal_enable = cal_reg;
	assign current_descriptor = cur_desc_reg;
	assign current_channel = chan_reg;
	assign irq = irq_reg;
	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_key_mid_load: assert property (wr_pend_reg && addr_reg == rpdc_pkg::OFF_KEY_MID |=>
		cipher_key_mid_high == $past(hwdata)) else $error("key 95:64 not loaded"); // RULE1
	a_key_top_load: assert property (wr_pend_reg && addr_reg == rpdc_pkg::OFF_KEY_TOP |=>
		cipher_key_top == $past(hwdata)) else $error("key 127:96 not loaded"); // RULE1
	a_power_max_flag: assert property (##1 power_at_max == ($past(radio_reg[4:0]) == rpdc_pkg::PWR_MAX))
		else $error("max power flag wrong"); // RULE2
	a_ptr_err_set: assert property (seq_advance && next_link_reg[1:0] != 2'h0 |=>
		status_reg[0] ##0 current_descriptor == $past(current_descriptor)) else $error("bad pointer taken"); // RULE6
	a_ptr_irq_gate: assert property (status_reg[0] && mask_reg[0] && !wr_pend_reg |=> irq)
		else $error("enabled pointer error gives no irq"); // RULE6
	a_cal_follow: assert property (seq_advance && next_link_reg[1:0] == 2'h0 |=>
		cal_enable == {4{$past(ctrl_reg[0])}}) else $error("calibration mismatch"); // RULE7
	a_inc_off_hold: assert property (seq_advance && !ctrl_reg[7] && !wr_pend_reg |=> $stable(current_channel))
		else $error("channel moved with incrementer off"); // RULE9
	a_adv_cycle: assert property (seq_advance && next_link_reg[1:0] == 2'h0 && ctrl_reg[7] && !ctrl_reg[1] &&
		ctrl_reg[5] && chan_reg == 6'h27 |=> current_channel == 6'h25) else $error("advertising wrap wrong"); // RULE10
	a_algo2_range: assert property (seq_advance && next_link_reg[1:0] == 2'h0 && ctrl_reg[7] && ctrl_reg[1] &&
		map_reg[0] && !wr_pend_reg |=> current_channel < 6'h25) else $error("algorithm 2 out of range"); // RULE11
	a_hop_event: assert property (hop_on |=> status_reg[1]) else $error("hop not flagged"); // RULE12
	c_read: cover property (rd_pend_reg ##1 hreadyout);
	c_ptr_err: cover property (ptr_bad ##1 irq);
	c_adv_hop: cover property (hop_on && ctrl_reg[5] && !ctrl_reg[1]);
	c_algo2: cover property (hop_on && ctrl_reg[1]);
endmodule
`default_nettype wire

// *** verif/rpdc_fw_model.sv ***
`default_nettype none
// firmware side: builds descriptor words over the register bus and steps the sequencer
module rpdc_fw_model (
	// clock and bus answer
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// ahb-lite master signals
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// sequencer step
	output logic seq_advance
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------
	// bus idle from time zero
	// ----------------------------------------------------------
	initial
	begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata, seq_advance} = '0;
	end
	// ----------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------
	// bounded wait for hready at an edge; a stuck slave ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1)
		begin
			rpdc_top_tb_top.failures++;
			rpdc_top_tb_top.final_report();
		end
	endtask
	// one single word transfer, address phase held until taken
	task automatic xfer(input logic w, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= rpdc_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, off};
		hwrite <= w;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? wd : 32'h0;
		wait_rdy();
		rd = hrdata;
	endtask
	// ----------------------------------------------------------
	// firmware duties
	// ----------------------------------------------------------
	// bypass only rides with the top code, so receive never sees it set
	task automatic set_power(input logic [4:0] code);
		logic [31:0] d;
		xfer(1'b1, rpdc_pkg::OFF_RADIO, {26'h0, code == rpdc_pkg::PWR_MAX, code}, d);
	endtask
	// single descriptor pointing at its own absolute address
	task automatic link_self(input logic [31:0] addr);
		logic [31:0] d;
		xfer(1'b1, rpdc_pkg::OFF_NEXT_LINK, addr, d);
	endtask
	// step request: calibration asked for on every channel change by the caller
	task automatic advance();
		seq_advance <= 1'b1;
		@(posedge hclk);
		seq_advance <= 1'b0;
		@(posedge hclk);
	endtask
endmodule
`default_nettype wire

// *** verif/rpdc_top_tb_top.sv ***
`default_nettype none
module rpdc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------
	// clock, reset, wires
	// ----------------------------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	wire logic hsel, hwrite, seq_advance, hreadyout, hresp, power_at_max, power_at_0dbm, power_off, bypass, irq;
	wire logic [31:0] haddr, hwdata, hrdata, key_mid, key_top, cur_desc;
	wire logic [1:0] htrans;
	wire logic [2:0] hsize;
	wire logic [4:0] pwr;
	wire logic [5:0] chan;
	wire rpdc_pkg::rpdc_cal_t cal;
	int failures = 0;
	int total_checks = 0;
	logic [4:0] codes [4] = '{5'h1f, 5'h19, 5'h10, 5'h00};
	logic [5:0] alg1_seq [5] = '{6'h0c, 6'h13, 6'h1a, 6'h21, 6'h03};
	logic [5:0] adv_seq [4] = '{6'h26, 6'h27, 6'h25, 6'h26};
	always #5 hclk = ~hclk;
	rpdc_top i_rpdc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .seq_advance(seq_advance), .cipher_key_mid_high(key_mid),
		.cipher_key_top(key_top), .transmit_power_code(pwr), .power_at_max(power_at_max),
		.power_at_0dbm(power_at_0dbm), .power_off(power_off), .transformer_regulator_bypass(bypass),
		.cal_enable(cal), .current_descriptor(cur_desc), .current_channel(chan), .irq(irq));
	rpdc_fw_model i_rpdc_fw_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.seq_advance(seq_advance));
	// ----------------------------------------------------------
	// compare and bus helpers
	// ----------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] r;
		i_rpdc_fw_model.xfer(1'b1, off, d, r);
		@(posedge hclk);
	endtask
	task automatic rchk(input logic [7:0] off, input logic [31:0] exp);
		logic [31:0] r;
		i_rpdc_fw_model.xfer(1'b0, off, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset state, then keys land on the engine outputs
		for (int i = 0; i < 5; i++) rchk(8'(4 * i), rpdc_pkg::RESET_WORD);
		rchk(rpdc_pkg::OFF_KEY_TOP, 32'h0);
		chk({31'h0, power_off}, 32'h1);
		wr(rpdc_pkg::OFF_KEY_MID, 32'h89ab_cdef);
		wr(rpdc_pkg::OFF_KEY_TOP, 32'h0123_4567);
		chk(key_mid, 32'h89ab_cdef);
		chk(key_top, 32'h0123_4567);
		rchk(rpdc_pkg::OFF_KEY_MID, 32'h89ab_cdef);
		rchk(8'h80, 32'h0);
		// power codes: top, 0 dbm, a middle one, off
		foreach (codes[i])
		begin
			i_rpdc_fw_model.set_power(codes[i]);
			repeat (2) @(posedge hclk);
			chk({27'h0, pwr}, {27'h0, codes[i]});
			chk({power_at_max, power_at_0dbm, power_off}, {codes[i] == 5'h1f, codes[i] == 5'h19, codes[i] == 5'h0});
			chk({31'h0, bypass}, {31'h0, codes[i] == 5'h1f});
		end
		// misaligned pointer while masked: flag only, step refused
		wr(rpdc_pkg::OFF_NEXT_LINK, 32'h0000_0102);
		i_rpdc_fw_model.advance();
		chk({31'h0, irq}, 32'h0);
		chk(cur_desc, 32'h0);
		rchk(rpdc_pkg::OFF_STATUS, 32'h1);
		wr(rpdc_pkg::OFF_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rchk(rpdc_pkg::OFF_IRQ_FLAGS, 32'h1);
		for (int k = 1; k < 4; k++)
		begin
			wr(rpdc_pkg::OFF_STATUS, 32'h1);
			chk({31'h0, irq}, 32'h0);
			wr(rpdc_pkg::OFF_NEXT_LINK, 32'h0000_0100 + k);
			i_rpdc_fw_model.advance();
			chk({31'h0, irq}, 32'h1);
		end
		wr(rpdc_pkg::OFF_STATUS, 32'h1);
		// self-linked descriptor with and without calibration
		i_rpdc_fw_model.link_self(32'h0000_0100);
		wr(rpdc_pkg::OFF_CTRL_A, 32'h1);
		i_rpdc_fw_model.advance();
		chk({28'h0, cal}, 32'hf);
		chk(cur_desc, 32'h0000_0100);
		wr(rpdc_pkg::OFF_CTRL_A, 32'h0);
		i_rpdc_fw_model.advance();
		chk({28'h0, cal}, 32'h0);
		rchk(rpdc_pkg::OFF_STATUS, 32'h0);
		// incrementer off with select 1: channel stays
		wr(rpdc_pkg::OFF_HOP, 32'h0000_0705);
		wr(rpdc_pkg::OFF_CTRL_A, 32'h3);
		i_rpdc_fw_model.advance();
		chk({26'h0, chan}, 32'h5);
		rchk(rpdc_pkg::OFF_STATUS, 32'h0);
		// algorithm 1 on data with the full map, wrapping past 36
		wr(rpdc_pkg::OFF_MAP_LO, 32'hffff_ffff);
		wr(rpdc_pkg::OFF_MAP_HI, 32'h0000_001f);
		wr(rpdc_pkg::OFF_CTRL_A, 32'h81);
		foreach (alg1_seq[i])
		begin
			i_rpdc_fw_model.advance();
			chk({26'h0, chan}, {26'h0, alg1_seq[i]});
		end
		rchk(rpdc_pkg::OFF_STATUS, 32'h2);
		// primary advertising cycles 37, 38, 39
		wr(rpdc_pkg::OFF_HOP, 32'h0000_0725);
		wr(rpdc_pkg::OFF_CTRL_A, 32'ha1);
		foreach (adv_seq[i])
		begin
			i_rpdc_fw_model.advance();
			chk({26'h0, chan}, {26'h0, adv_seq[i]});
		end
		// algorithm 2 with only channel 0 usable lands on 0, data and periodic
		wr(rpdc_pkg::OFF_MAP_LO, 32'h1);
		wr(rpdc_pkg::OFF_MAP_HI, 32'h0);
		wr(rpdc_pkg::OFF_COUNTERS, 32'h0003_0005);
		wr(rpdc_pkg::OFF_CTRL_A, 32'h83);
		i_rpdc_fw_model.advance();
		chk({26'h0, chan}, 32'h0);
		wr(rpdc_pkg::OFF_HOP, 32'h0000_070a);
		wr(rpdc_pkg::OFF_CTRL_A, 32'ha3);
		i_rpdc_fw_model.advance();
		chk({26'h0, chan}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
